// ---- hdl/hpp_pkg.sv ----
// shared constants and helpers for both ends of the host processor port
// assumes a 40 MHz system clock on both ends and a 200 ns serial clock
package hpp_pkg;
  // ==========================================================
  // widths
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int SHORT_ADDR_W = 5;
  localparam int HI_ADDR_W = 6;
  // ==========================================================
  // control byte fields (stream order, first bit is bit 7) and strap bits on the data pins
  localparam int CTRL_RW_BIT = 7;
  localparam int CTRL_EXT_BIT = 6;
  localparam int CTRL_BURST_BIT = 0;
  localparam int STRAP_CPOL_BIT = 7;
  localparam int STRAP_CPHA_BIT = 6;
  localparam int STRAP_SWAP_BIT = 5;
  // ==========================================================
  // reset values
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;
  localparam logic [DATA_W-1:0] BUS_IDLE = 8'hFF;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int SCLK_PERIOD_NS = 200;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int SPI_FRAME_BITS = 24;
  localparam int SPI_HALVES = 2 * SPI_FRAME_BITS;
  localparam int PAR_SETUP_CYC = 2;
  localparam int PAR_STROBE_NS = 400;
  localparam int PAR_STROBE_CYC = (PAR_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAR_HOLD_NS = 200;
  localparam int PAR_HOLD_CYC = (PAR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_NS = 200;
  localparam int GAP_CYC = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // bit order swap of a data byte
  function automatic logic [DATA_W-1:0] rev8(input logic [DATA_W-1:0] v);
    for (int i = 0; i < DATA_W; i++) begin
      rev8[i] = v[DATA_W-1-i];
    end
  endfunction

  // bit order swap of an address field
  function automatic logic [ADDR_W-1:0] rev13(input logic [ADDR_W-1:0] v);
    for (int i = 0; i < ADDR_W; i++) begin
      rev13[i] = v[ADDR_W-1-i];
    end
  endfunction
endpackage

// ---- hdl/hpp_port_if.sv ----
// pins between the host processor and the device port
// assumes the bench joins both ends; shared pins are resolved here
`timescale 1ns/1ps
interface hpp_port_if;
  import hpp_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] host_data;
  logic host_data_oe_n;
  logic [DATA_W-1:0] dev_data;
  logic dev_data_oe_n;
  logic [DATA_W-1:0] data_bus;
  logic port_select_n;
  logic read_strobe_n;
  logic write_strobe_n;
  logic direction_line;
  logic data_latch_strobe_n;
  logic bus_style_strap;
  logic serial_select_strap;
  logic spi_sclk;
  logic spi_mosi;
  logic spi_miso;
  logic irq_drive;
  logic irq_oe_n;
  logic irq_out_n;
  logic hard_reset_n;
  logic test_scan_select;

  // data bus: device wins, else host, else pulled high
  assign data_bus = !dev_data_oe_n ? dev_data : (!host_data_oe_n ? host_data : BUS_IDLE);
  // open-drain interrupt with pull-up
  assign irq_out_n = irq_oe_n ? 1'b1 : irq_drive;

  modport dev(
    input addr, data_bus, port_select_n, read_strobe_n, write_strobe_n,
    input direction_line, data_latch_strobe_n, bus_style_strap, serial_select_strap,
    input spi_sclk, spi_mosi, hard_reset_n, test_scan_select,
    output dev_data, dev_data_oe_n, spi_miso, irq_drive, irq_oe_n
  );
  modport host(
    output addr, host_data, host_data_oe_n, port_select_n, read_strobe_n,
    output write_strobe_n, direction_line, data_latch_strobe_n, bus_style_strap,
    output serial_select_strap, spi_sclk, spi_mosi, hard_reset_n, test_scan_select,
    input data_bus, spi_miso, irq_out_n
  );
endinterface

// ---- hdl/hpp_dev.sv ----
// device end of the host processor port: parallel and serial slave
// assumes all pins come from another clock domain; the register space
// sits behind the user-side port, read data one cycle after the strobe
`timescale 1ns/1ps
module hpp_dev
  import hpp_pkg::*;
(
  input wire logic clock_i, // master clock, free running
  input wire logic sys_rst_i, // synchronous reset, active high
  hpp_port_if.dev port, // pins toward the host
  output logic [ADDR_W-1:0] reg_addr_o, // register address
  output logic [DATA_W-1:0] reg_wdata_o, // register write data
  output logic reg_we_o, // write pulse
  output logic reg_re_o, // read pulse
  input wire logic [DATA_W-1:0] reg_rdata_i, // read data, one cycle after read
  input wire logic irq_req_i, // any enabled interrupt condition
  output logic core_rst_o // reset to the register space
);
  // ==========================================================
  // pin synchronisers
  localparam int PIN_W = 10;
  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_s;
  logic [ADDR_W-1:0] addr_meta;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_meta;
  logic [DATA_W-1:0] data_s;

  // two flops on every pin except the unused test_scan_select; only the second one is read
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pin_meta <= 10'h3FF;
      pin_s <= 10'h3FF;
      addr_meta <= ADDR_RST;
      addr_s <= ADDR_RST;
      data_meta <= DATA_RST;
      data_s <= DATA_RST;
    end else begin
      pin_meta <= {port.hard_reset_n, port.serial_select_strap, port.bus_style_strap,
                   port.port_select_n, port.read_strobe_n, port.write_strobe_n,
                   port.direction_line, port.data_latch_strobe_n, port.spi_sclk,
                   port.spi_mosi};
      pin_s <= pin_meta;
      addr_meta <= port.addr;
      addr_s <= addr_meta;
      data_meta <= port.data_bus;
      data_s <= data_meta;
    end
  end

  logic hard_n_s, serial_s, style_s, sel_n_s, rd_n_s, wr_n_s, dir_s, ds_n_s, sclk_s, mosi_s;
  assign {hard_n_s, serial_s, style_s, sel_n_s, rd_n_s, wr_n_s, dir_s, ds_n_s, sclk_s,
          mosi_s} = pin_s;

  // hard reset pin joins the system reset for all port state past the pin synchronisers, which take sys_rst_i only
  logic rst;
  assign rst = sys_rst_i | ~hard_n_s;

  // ==========================================================
  // core reset and interrupt pin
  // interrupt is level only; the masking lives in the register space
  always_ff @(posedge clock_i) begin
    core_rst_o <= rst;
  end

  always_ff @(posedge clock_i) begin
    if (rst) begin
      port.irq_oe_n <= 1'b1;
    end else begin
      port.irq_oe_n <= ~irq_req_i;
    end
  end
  assign port.irq_drive = 1'b0;

  // ==========================================================
  // parallel strobe decode
  logic rd_act, wr_act, rd_prev, wr_prev, sel_ok;
  logic par_rd_go, par_wr_go;
  assign sel_ok = ~sel_n_s & ~serial_s;
  assign rd_act = style_s ? (~ds_n_s & dir_s) : ~rd_n_s;
  assign wr_act = style_s ? (~ds_n_s & ~dir_s) : ~wr_n_s;
  assign par_rd_go = sel_ok & rd_act & ~rd_prev;
  // write is latched on the closing edge so the data pins have settled
  assign par_wr_go = sel_ok & wr_prev & ~wr_act;

  always_ff @(posedge clock_i) begin
    if (rst) begin
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
    end else begin
      rd_prev <= rd_act;
      wr_prev <= wr_act;
    end
  end

  // ==========================================================
  // serial edge detect
  logic cpol, cpha, swap, sclk_p, rise, fall, lead, trail, samp, shft, spi_on;
  assign cpol = data_s[STRAP_CPOL_BIT];
  assign cpha = data_s[STRAP_CPHA_BIT];
  assign swap = data_s[STRAP_SWAP_BIT];
  assign spi_on = serial_s & ~sel_n_s;
  assign rise = sclk_s & ~sclk_p;
  assign fall = ~sclk_s & sclk_p;
  assign lead = cpol ? fall : rise;
  assign trail = cpol ? rise : fall;
  assign samp = spi_on & (cpha ? trail : lead);
  assign shft = spi_on & (cpha ? lead : trail);

  always_ff @(posedge clock_i) begin
    if (rst) begin
      sclk_p <= 1'b0;
    end else begin
      sclk_p <= sclk_s;
    end
  end

  // ==========================================================
  // serial byte assembly and access sequencing
  typedef enum logic [1:0] {SP_CTRL0, SP_CTRL1, SP_DATA} hpp_spi_st_t;
  hpp_spi_st_t st;
  logic [DATA_W-1:0] rx;
  logic [2:0] bitcnt;
  logic rw, burst;
  logic [HI_ADDR_W-1:0] hi_addr;
  logic [ADDR_W-1:0] spi_addr, next_addr, full_addr, short_addr, short_rev;
  logic [DATA_W-1:0] byte_val;
  logic byte_done, spi_rd_go, spi_wr_go;

  assign byte_done = samp & (bitcnt == 3'h7);
  assign byte_val = {rx[DATA_W-2:0], mosi_s};
  assign full_addr = {hi_addr, byte_val[DATA_W-1:1]};
  assign short_rev = rev13({8'h00, byte_val[SHORT_ADDR_W:1]});
  assign short_addr = swap ? {8'h00, short_rev[ADDR_W-1:ADDR_W-SHORT_ADDR_W]}
                           : {8'h00, byte_val[SHORT_ADDR_W:1]};

  // address for the access that this byte opens
  always_comb begin
    next_addr = spi_addr;
    unique case (st)
      SP_CTRL0: next_addr = short_addr;
      SP_CTRL1: next_addr = swap ? rev13(full_addr) : full_addr;
      SP_DATA: next_addr = spi_addr + 13'h0001;
    endcase
  end

  assign spi_rd_go = byte_done & (((st == SP_CTRL0) & ~byte_val[CTRL_EXT_BIT]
                                   & byte_val[CTRL_RW_BIT])
                                  | ((st == SP_CTRL1) & rw)
                                  | ((st == SP_DATA) & rw & burst));
  assign spi_wr_go = byte_done & (st == SP_DATA) & ~rw;

  // bit counter and receive shifter; select high restarts a byte
  always_ff @(posedge clock_i) begin
    if (rst || sel_n_s) begin
      rx <= DATA_RST;
      bitcnt <= 3'h0;
    end else if (samp) begin
      rx <= byte_val;
      bitcnt <= bitcnt + 3'h1;
    end
  end

  // access sequencer: one or two control bytes, then data bytes
  always_ff @(posedge clock_i) begin
    if (rst || sel_n_s) begin
      st <= SP_CTRL0;
      rw <= 1'b0;
      burst <= 1'b0;
      hi_addr <= 6'h00;
      spi_addr <= ADDR_RST;
    end else if (byte_done) begin
      unique case (st)
        SP_CTRL0: begin
          rw <= byte_val[CTRL_RW_BIT];
          if (byte_val[CTRL_EXT_BIT]) begin
            hi_addr <= byte_val[HI_ADDR_W-1:0];
            st <= SP_CTRL1;
          end else begin
            burst <= byte_val[CTRL_BURST_BIT];
            spi_addr <= next_addr;
            st <= SP_DATA;
          end
        end
        SP_CTRL1: begin
          burst <= byte_val[CTRL_BURST_BIT];
          spi_addr <= next_addr;
          st <= SP_DATA;
        end
        SP_DATA: begin
          if (burst) begin
            spi_addr <= next_addr;
          end else begin
            st <= SP_CTRL0;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // register side port; one source at a time by the mode strap
  logic rd_pend;
  always_ff @(posedge clock_i) begin
    if (rst) begin
      reg_addr_o <= ADDR_RST;
      reg_wdata_o <= DATA_RST;
      reg_we_o <= 1'b0;
      reg_re_o <= 1'b0;
      rd_pend <= 1'b0;
    end else begin
      reg_we_o <= 1'b0;
      reg_re_o <= 1'b0;
      rd_pend <= reg_re_o;
      if (par_rd_go) begin
        reg_addr_o <= addr_s;
        reg_re_o <= 1'b1;
      end else if (par_wr_go) begin
        reg_addr_o <= addr_s;
        reg_wdata_o <= data_s;
        reg_we_o <= 1'b1;
      end else if (spi_wr_go) begin
        reg_addr_o <= spi_addr;
        reg_wdata_o <= swap ? rev8(byte_val) : byte_val;
        reg_we_o <= 1'b1;
      end else if (spi_rd_go) begin
        reg_addr_o <= next_addr;
        reg_re_o <= 1'b1;
      end
    end
  end

  // ==========================================================
  // parallel read data drive; bus released as the strobe closes
  always_ff @(posedge clock_i) begin
    if (rst) begin
      port.dev_data <= DATA_RST;
      port.dev_data_oe_n <= 1'b1;
    end else begin
      port.dev_data_oe_n <= ~(sel_ok & rd_act);
      if (rd_pend && !serial_s) begin
        port.dev_data <= reg_rdata_i;
      end
    end
  end

  // ==========================================================
  // serial read data: loaded after the byte that opens the read,
  // then shifted on each shift edge after the first data bit
  logic [DATA_W-1:0] tx;
  always_ff @(posedge clock_i) begin
    if (rst || sel_n_s) begin
      tx <= DATA_RST;
    end else if (rd_pend && serial_s) begin
      tx <= swap ? rev8(reg_rdata_i) : reg_rdata_i;
    end else if (shft && (st == SP_DATA) && (bitcnt != 3'h0)) begin
      tx <= {tx[DATA_W-2:0], 1'b0};
    end
  end
  assign port.spi_miso = tx[DATA_W-1];
endmodule

// ---- hdl/hpp_host.sv ----
// host end of the processor port: parallel or serial master
// assumes the device end samples every pin but test_scan_select through two flops;
// one access per command, user port on the same clock
`timescale 1ns/1ps
module hpp_host
  import hpp_pkg::*;
(
  input wire logic clock_i, // system clock
  input wire logic sys_rst_i, // synchronous reset, active high
  hpp_port_if.host port, // pins toward the device
  input wire logic [ADDR_W-1:0] cmd_addr_i, // register address
  input wire logic [DATA_W-1:0] cmd_wdata_i, // write data
  input wire logic cmd_write_i, // write request pulse
  input wire logic cmd_read_i, // read request pulse
  input wire logic use_serial_i, // pick serial mode
  input wire logic bus_style_i, // strobe style in parallel mode
  input wire logic cpol_i, // serial clock idle level
  input wire logic cpha_i, // serial clock phase
  input wire logic swap_i, // lsb first fields
  input wire logic hard_reset_i, // hold the device in reset
  output logic busy_o, // access in progress
  output logic done_o, // access finished pulse
  output logic [DATA_W-1:0] rdata_o, // last read data
  output logic irq_o // interrupt line seen low
);
  typedef enum logic [1:0] {H_IDLE, H_PAR, H_SPI, H_GAP} hpp_host_st_t;
  hpp_host_st_t st;
  logic [5:0] cnt;
  logic [5:0] half;
  logic [SPI_FRAME_BITS-1:0] frame;
  logic [DATA_W-1:0] rx;
  logic rw, cpha;
  logic [DATA_W-1:0] miso_meta, data_s;
  logic [DATA_W-1:0] data_meta;
  logic miso_s, irq_meta, irq_s;
  logic [5:0] nhalf, bidx;
  logic [ADDR_W-1:0] a_tx;
  logic [DATA_W-1:0] rx_in;

  // ==========================================================
  // input synchronisers
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      data_meta <= BUS_IDLE;
      data_s <= BUS_IDLE;
      miso_meta <= DATA_RST;
      miso_s <= 1'b0;
      irq_meta <= 1'b1;
      irq_s <= 1'b1;
      irq_o <= 1'b0;
    end else begin
      data_meta <= port.data_bus;
      data_s <= data_meta;
      miso_meta <= {7'h00, port.spi_miso};
      miso_s <= miso_meta[0];
      irq_meta <= port.irq_out_n;
      irq_s <= irq_meta;
      irq_o <= ~irq_s;
    end
  end

  // ==========================================================
  // straps and reset pin
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      port.hard_reset_n <= 1'b0;
      port.test_scan_select <= 1'b0;
      port.serial_select_strap <= 1'b0;
      port.bus_style_strap <= 1'b0;
    end else begin
      port.hard_reset_n <= ~hard_reset_i;
      port.test_scan_select <= 1'b0;
      port.serial_select_strap <= use_serial_i;
      port.bus_style_strap <= bus_style_i & ~use_serial_i;
    end
  end

  // mosi bit for a given half period of the frame
  assign nhalf = half + 6'h01;
  assign bidx = cpha ? ((nhalf - 6'h01) >> 1) : (nhalf >> 1);
  assign a_tx = swap_i ? rev13(cmd_addr_i) : cmd_addr_i;
  // miso bit taken at the end of a sample half; the last one of a
  // phase-one frame lands in the same cycle that closes the frame
  assign rx_in = (half[0] != cpha && half != 6'h00) ? {rx[DATA_W-2:0], miso_s} : rx;

  // ==========================================================
  // access sequencer
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st <= H_IDLE;
      cnt <= 6'h00;
      half <= 6'h00;
      frame <= 24'h000000;
      rx <= DATA_RST;
      rw <= 1'b0;
      cpha <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      rdata_o <= DATA_RST;
      port.addr <= ADDR_RST;
      port.host_data <= DATA_RST;
      port.host_data_oe_n <= 1'b1;
      port.port_select_n <= 1'b1;
      port.read_strobe_n <= 1'b1;
      port.write_strobe_n <= 1'b1;
      port.direction_line <= 1'b1;
      port.data_latch_strobe_n <= 1'b1;
      port.spi_sclk <= 1'b0;
      port.spi_mosi <= 1'b0;
    end else begin
      done_o <= 1'b0;
      cnt <= cnt + 6'h01;
      unique case (st)
        H_IDLE: begin
          cnt <= 6'h00;
          half <= 6'h00;
          port.spi_sclk <= cpol_i;
          // straps for the serial slave ride on the data pins
          port.host_data <= use_serial_i ? {cpol_i, cpha_i, swap_i, 5'h00} : DATA_RST;
          port.host_data_oe_n <= ~use_serial_i;
          if (cmd_write_i || cmd_read_i) begin
            rw <= cmd_read_i;
            cpha <= cpha_i;
            busy_o <= 1'b1;
            port.port_select_n <= 1'b0;
            if (use_serial_i) begin
              frame <= {cmd_read_i, 1'b1, a_tx[ADDR_W-1:7], a_tx[6:0], 1'b0,
                        swap_i ? rev8(cmd_wdata_i) : cmd_wdata_i};
              port.spi_mosi <= cmd_read_i;
              st <= H_SPI;
            end else begin
              port.addr <= cmd_addr_i;
              port.host_data <= cmd_wdata_i;
              port.host_data_oe_n <= cmd_read_i;
              port.direction_line <= cmd_read_i;
              st <= H_PAR;
            end
          end
        end
        H_PAR: begin
          if (cnt == 6'(PAR_SETUP_CYC)) begin
            port.read_strobe_n <= ~(rw & ~bus_style_i);
            port.write_strobe_n <= ~(~rw & ~bus_style_i);
            port.data_latch_strobe_n <= ~bus_style_i;
          end else if (cnt == 6'(PAR_SETUP_CYC + PAR_STROBE_CYC)) begin
            rx <= data_s;
            port.read_strobe_n <= 1'b1;
            port.write_strobe_n <= 1'b1;
            port.data_latch_strobe_n <= 1'b1;
          end else if (cnt == 6'(PAR_SETUP_CYC + PAR_STROBE_CYC + PAR_HOLD_CYC)) begin
            port.host_data_oe_n <= 1'b1;
            port.port_select_n <= 1'b1;
            rdata_o <= rw ? rx : rdata_o;
            cnt <= 6'h00;
            st <= H_GAP;
          end
        end
        H_SPI: begin
          if (cnt == 6'(SCLK_HALF_CYC - 1)) begin
            cnt <= 6'h00;
            half <= nhalf;
            // sample the synchronised miso late in each sample half
            rx <= rx_in;
            if (half == 6'(SPI_HALVES)) begin
              port.port_select_n <= 1'b1;
              rdata_o <= rw ? (swap_i ? rev8(rx_in) : rx_in) : rdata_o;
              st <= H_GAP;
            end else begin
              port.spi_sclk <= (nhalf == 6'(SPI_HALVES)) ? cpol_i : (cpol_i ^ nhalf[0]);
              // the closing half of a phase-zero frame has no bit left to show
              if (bidx < 6'(SPI_FRAME_BITS)) begin
                port.spi_mosi <= frame[5'(SPI_FRAME_BITS - 1) - bidx[4:0]];
              end
            end
          end
        end
        H_GAP: begin
          // select stays high long enough for the device to see it
          if (cnt == 6'(GAP_CYC)) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
            st <= H_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// ---- test/hpp_port_monitor.sv ----
// concurrent checks on the pins between the host end and the device end
// assumes one clock domain; the bench instantiates it beside the interface
`timescale 1ns/1ps
module hpp_port_monitor (
  input wire logic clock_i, // system clock
  input wire logic sys_rst_i, // sync reset, high
  input wire logic port_select_n, // port select
  input wire logic read_strobe_n, // style one read
  input wire logic write_strobe_n, // style one write
  input wire logic direction_line, // high reads
  input wire logic data_latch_strobe_n, // style two strobe
  input wire logic bus_style_strap, // strobe style
  input wire logic serial_select_strap, // serial mode
  input wire logic dev_data_oe_n, // device drives bus
  input wire logic host_data_oe_n, // host drives bus
  input wire logic hard_reset_n, // device reset pin
  input wire logic irq_out_n, // resolved interrupt
  input wire logic irq_req_i, // interrupt request
  input wire logic core_rst_o // register space reset
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // ==========================================================
  // read openings; the device answers a few cycles late through its synchronisers
  sequence rd_open;
    $fell(read_strobe_n) && !bus_style_strap;
  endsequence
  sequence ds_rd_open;
    $fell(data_latch_strobe_n) && bus_style_strap && direction_line;
  endsequence
  // ==========================================================
  // bus ownership and strobes
  sel_strobe_a: assert property ((!read_strobe_n || !write_strobe_n || !data_latch_strobe_n) |-> !port_select_n) else $error("strobe without select");
  no_fight_a: assert property (!dev_data_oe_n |-> host_data_oe_n) else $error("both ends drive data");
  drive_sel_a: assert property (!dev_data_oe_n |-> !port_select_n) else $error("device drives unselected");
  style_dir_a: assert property ((!dev_data_oe_n && bus_style_strap) |-> direction_line) else $error("device drives on write");
  read_one_a: assert property (rd_open |-> ##[1:8] !dev_data_oe_n) else $error("no read data, style one");
  read_two_a: assert property (ds_rd_open |-> ##[1:8] !dev_data_oe_n) else $error("no read data, style two");
  serial_quiet_a: assert property (serial_select_strap |-> dev_data_oe_n) else $error("parallel drive in serial");
  // ==========================================================
  // interrupt line and hard reset
  irq_low_a: assert property (irq_req_i |-> ##[0:4] !irq_out_n) else $error("interrupt not pulled");
  irq_free_a: assert property (!irq_req_i [*4] |-> irq_out_n) else $error("interrupt stuck low");
  hard_rst_a: assert property (!hard_reset_n [*4] |-> core_rst_o) else $error("hard reset ignored");
endmodule

// ---- test/test_host_processor_port_parallel_spi.sv ----
// bench joining host and device ends; the register space is modelled here
// assumes read data one cycle after the read pulse, as the device expects
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module test_host_processor_port_parallel_spi;
  import hpp_pkg::*;
  logic clock_i = 1'b0, sys_rst_i = 1'b1;
  logic [ADDR_W-1:0] cmd_addr = ADDR_RST;
  logic [DATA_W-1:0] cmd_wdata = DATA_RST;
  logic cmd_write = 1'b0, cmd_read = 1'b0, use_serial = 1'b0, bus_style = 1'b0;
  logic cpol = 1'b0, cpha = 1'b0, swap = 1'b0, hard_reset = 1'b0, irq_req = 1'b0;
  logic busy, done, irq_seen, core_rst, reg_we, reg_re;
  logic [ADDR_W-1:0] reg_addr, last_waddr;
  logic [DATA_W-1:0] rdata, reg_wdata, reg_rdata, last_wdata;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  int fail_count = 0, checks = 0, cycles = 0;
  hpp_port_if port_bus ();
  hpp_host i_hpp_host (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .port(port_bus),
    .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata), .cmd_write_i(cmd_write),
    .cmd_read_i(cmd_read), .use_serial_i(use_serial), .bus_style_i(bus_style),
    .cpol_i(cpol), .cpha_i(cpha), .swap_i(swap), .hard_reset_i(hard_reset),
    .busy_o(busy), .done_o(done), .rdata_o(rdata), .irq_o(irq_seen));
  hpp_dev i_hpp_dev (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .port(port_bus),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_we_o(reg_we), .reg_re_o(reg_re),
    .reg_rdata_i(reg_rdata), .irq_req_i(irq_req), .core_rst_o(core_rst));
  hpp_port_monitor i_hpp_port_monitor (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .port_select_n(port_bus.port_select_n), .read_strobe_n(port_bus.read_strobe_n),
    .write_strobe_n(port_bus.write_strobe_n), .direction_line(port_bus.direction_line),
    .data_latch_strobe_n(port_bus.data_latch_strobe_n),
    .bus_style_strap(port_bus.bus_style_strap),
    .serial_select_strap(port_bus.serial_select_strap),
    .dev_data_oe_n(port_bus.dev_data_oe_n), .host_data_oe_n(port_bus.host_data_oe_n),
    .hard_reset_n(port_bus.hard_reset_n), .irq_out_n(port_bus.irq_out_n),
    .irq_req_i(irq_req), .core_rst_o(core_rst));
  // ==========================================================
  // clock, and a ceiling well above ten modes of two accesses each
  initial begin
    forever #12.5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  // register space; the last write is kept so address and data can be compared
  always @(posedge clock_i) begin
    reg_rdata <= mem[reg_addr];
    if (reg_we) begin
      mem[reg_addr] <= reg_wdata;
      last_waddr <= reg_addr;
      last_wdata <= reg_wdata;
    end
  end
  // ==========================================================
  // straps change only inside reset, since the device reads them continuously
  task automatic restart(input logic ser, input logic sty, input logic [2:0] k);
    @(posedge clock_i);
    sys_rst_i <= 1'b1;
    use_serial <= ser;
    bus_style <= sty;
    {cpol, cpha, swap} <= k;
    repeat (5) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    repeat (8) @(posedge clock_i);
  endtask
  // one command pulse, then wait for done sampled away from the rising edge
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_write <= wr;
    cmd_read <= !wr;
    @(posedge clock_i);
    cmd_write <= 1'b0;
    cmd_read <= 1'b0;
    @(negedge clock_i);
    `CHK(busy, 1'b1)
    while (done !== 1'b1 && n < 400) begin
      @(negedge clock_i);
      n++;
    end
    `CHK(n < 400, 1'b1)
    `CHK(busy, 1'b0)
  endtask
  task automatic finish_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================================
  // both strobe styles, then all eight serial strap settings
  initial begin
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    for (int m = 0; m < 10; m++) begin
      a = m[0] ? ADDR_W'(13'h1FFF - m) : ADDR_W'(13'h0001 << m);
      d = {4'(m), ~4'(m)};
      restart(m > 1, m == 1, 3'(m - 2));
      access(1'b1, a, d);
      `CHK(last_waddr, a)
      `CHK(last_wdata, d)
      access(1'b0, a, 8'h00);
      `CHK(rdata, d)
    end
    @(posedge clock_i);
    irq_req <= 1'b1;
    repeat (8) @(negedge clock_i);
    `CHK(irq_seen, 1'b1)
    @(posedge clock_i);
    irq_req <= 1'b0;
    repeat (8) @(negedge clock_i);
    `CHK(irq_seen, 1'b0)
    @(posedge clock_i);
    hard_reset <= 1'b1;
    repeat (8) @(negedge clock_i);
    `CHK(core_rst, 1'b1)
    @(posedge clock_i);
    hard_reset <= 1'b0;
    repeat (8) @(negedge clock_i);
    `CHK(core_rst, 1'b0)
    access(1'b0, a, 8'h00);
    `CHK(rdata, d)
    finish_test();
  end
endmodule
